// ### core/emi_ctrl.sv
// Purpose: decodes external-move accesses into on-chip memory or an off-chip bus
// Assumes: core holds the request fields stable in the cycle of the request
// Notes:   pin output modes stay with the port logic, only enables are given here
`timescale 1ns/10ps
`include "emi_map.svh"

module emi_ctrl
   import emi_pkg::*;
#(
   parameter logic [3:0] SETUP_CYC  = `EMI_SETUP_CYC,
   parameter logic [3:0] STROBE_CYC = `EMI_STROBE_CYC,
   parameter logic [3:0] HOLD_CYC   = `EMI_HOLD_CYC
) (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   // register port
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   input  wire logic [7:0]  sfr_wdata_i,
   output logic      [7:0]  sfr_rdata_o,
   // external-move request from the core
   input  wire logic        xmove_req_i,
   input  wire logic        xmove_wr_i,
   input  wire logic        xmove_ptr8_i,
   input  wire logic [15:0] data_pointer_16_i,
   input  wire logic [7:0]  indirect_pointer_i,
   input  wire logic [7:0]  xmove_wdata_i,
   output logic      [7:0]  xmove_rdata_o,
   output logic             xmove_done_o,
   output logic             xmove_busy_o,
   // shared data / low address pins
   input  wire logic [7:0]  ad_i,
   output logic      [7:0]  ad_o,
   output logic             ad_oe_o,
   // separate low address pins
   output logic      [7:0]  addr_lo_o,
   output logic             addr_lo_oe_o,
   // upper address pins
   output logic      [7:0]  addr_hi_o,
   output logic             addr_hi_oe_o,
   // control strobes
   output logic             ale_o,
   output logic             ale_oe_o,
   output logic             rd_n_o,
   output logic             wr_n_o,
   output logic             strobe_oe_o
);
   emi_regs_t s;
   emi_regs_t next_s;

   logic [15:0]                eff_addr;
   logic [1:0]                 mode;
   logic                       mux_mode_select;
   logic [1:0]                 latch_pulse_width;
   logic                       onchip;
   logic                       hi_drive;
   logic                       tm_load;
   logic [`EMI_TIMER_W-1:0]    tm_val;
   logic                       tm_expired;
   logic                       ram_en;
   logic                       ram_we;

   emi_ram_if #(.AW(`EMI_ONCHIP_AW), .DW(8)) ram_bus ();

   emi_ram #(
      .AW (`EMI_ONCHIP_AW),
      .DW (8)
   ) u_ram (
      .mclk_i (mclk_i),
      .bus    (ram_bus.mem)
   );

   emi_phase_timer #(
      .W (`EMI_TIMER_W)
   ) u_timer (
      .mclk_i     (mclk_i),
      .reset_i    (reset_i),
      .load_i     (tm_load),
      .load_val_i (tm_val),
      .expired_o  (tm_expired)
   );

   assign mode              = s.interface_config_register[`EMI_CFG_MODE_HI:`EMI_CFG_MODE_LO];
   assign mux_mode_select   = s.interface_config_register[`EMI_CFG_MUX_BIT];
   assign latch_pulse_width = s.interface_config_register[`EMI_CFG_ALE_HI:`EMI_CFG_ALE_LO];

   // effective address and target decode
   always_comb begin
      if (!xmove_ptr8_i) begin
         eff_addr = data_pointer_16_i;
      end else if (mode == `EMI_MODE_OFFCHIP) begin
         eff_addr = {8'h00, indirect_pointer_i};
      end else begin
         eff_addr = {s.page_select_register, indirect_pointer_i};
      end
      unique case (mode)
         `EMI_MODE_ONCHIP:  onchip = 1'b1;
         `EMI_MODE_OFFCHIP: onchip = 1'b0;
         default:           onchip = (eff_addr < `EMI_ONCHIP_LIMIT);
      endcase
      hi_drive = !xmove_ptr8_i || (mode == `EMI_MODE_BANK);
   end

   assign ram_bus.en    = ram_en;
   assign ram_bus.we    = ram_we;
   assign ram_bus.addr  = eff_addr[`EMI_ONCHIP_AW-1:0];
   assign ram_bus.wdata = xmove_wdata_i;

   always_comb begin
      next_s  = s;
      next_s.done = 1'b0;
      tm_load = 1'b0;
      tm_val  = '0;
      ram_en  = 1'b0;
      ram_we  = 1'b0;

      // register writes
      if (sfr_wr_i && sfr_addr_i == `EMI_PAGE_SEL_ADDR) begin
         next_s.page_select_register = sfr_wdata_i;
      end
      if (sfr_wr_i && sfr_addr_i == `EMI_CONFIG_ADDR) begin
         next_s.interface_config_register =
            sfr_wdata_i[`EMI_CFG_WIDTH-1:0] & `EMI_CFG_WMASK;
      end
      // register reads
      if (sfr_rd_i) begin
         unique case (sfr_addr_i)
            `EMI_PAGE_SEL_ADDR: next_s.sfr_rdata = s.page_select_register;
            `EMI_CONFIG_ADDR:   next_s.sfr_rdata = {3'h0, s.interface_config_register};
            default:            next_s.sfr_rdata = 8'h00;
         endcase
      end

      unique case (s.state)
         EMI_IDLE: begin
            if (xmove_req_i) begin
               next_s.busy   = 1'b1;
               next_s.acc_wr = xmove_wr_i;
               next_s.addr   = eff_addr;
               next_s.wdata  = xmove_wdata_i;
               if (onchip) begin
                  ram_en       = 1'b1;
                  ram_we       = xmove_wr_i;
                  next_s.state = EMI_ON_WAIT;
               end else begin
                  tm_load          = 1'b1;
                  next_s.strobe_oe = 1'b1;
                  next_s.rd_n      = 1'b1;
                  next_s.wr_n      = 1'b1;
                  next_s.ahi_oe    = hi_drive;
                  next_s.ale_oe    = !mux_mode_select;
                  next_s.alo_oe    = mux_mode_select;
                  if (!mux_mode_select) begin
                     next_s.ale    = 1'b1;
                     next_s.ad_out = eff_addr[7:0];
                     next_s.ad_oe  = 1'b1;
                     tm_val        = {2'h0, latch_pulse_width};
                     next_s.state  = EMI_ALE_HIGH;
                  end else begin
                     next_s.ale    = 1'b0;
                     next_s.ad_out = xmove_wdata_i;
                     next_s.ad_oe  = xmove_wr_i;
                     tm_val        = SETUP_CYC;
                     next_s.state  = EMI_ADDR;
                  end
               end
            end
         end
         EMI_ON_WAIT: begin
            if (!s.acc_wr) begin
               next_s.rdata = ram_bus.rdata;
            end
            next_s.done  = 1'b1;
            next_s.busy  = 1'b0;
            next_s.state = EMI_IDLE;
         end
         EMI_ALE_HIGH: begin
            if (tm_expired) begin
               tm_load      = 1'b1;
               tm_val       = {2'h0, latch_pulse_width};
               next_s.ale   = 1'b0;
               next_s.state = EMI_ALE_LOW;
            end
         end
         EMI_ALE_LOW: begin
            if (tm_expired) begin
               tm_load       = 1'b1;
               tm_val        = SETUP_CYC;
               next_s.ad_out = s.wdata;
               next_s.ad_oe  = s.acc_wr;
               next_s.state  = EMI_ADDR;
            end
         end
         EMI_ADDR: begin
            if (tm_expired) begin
               tm_load      = 1'b1;
               tm_val       = STROBE_CYC - 4'h1;
               next_s.rd_n  = s.acc_wr;
               next_s.wr_n  = !s.acc_wr;
               next_s.state = EMI_STROBE;
            end
         end
         EMI_STROBE: begin
            if (tm_expired) begin
               tm_load      = 1'b1;
               tm_val       = HOLD_CYC;
               next_s.rd_n  = 1'b1;
               next_s.wr_n  = 1'b1;
               if (!s.acc_wr) begin
                  next_s.rdata = ad_i;
               end
               next_s.state = EMI_HOLD;
            end
         end
         EMI_HOLD: begin
            if (tm_expired) begin
               next_s.ad_oe     = 1'b0;
               next_s.alo_oe    = 1'b0;
               next_s.ahi_oe    = 1'b0;
               next_s.ale_oe    = 1'b0;
               next_s.strobe_oe = 1'b0;
               next_s.done      = 1'b1;
               next_s.busy      = 1'b0;
               next_s.state     = EMI_IDLE;
            end
         end
         default: begin
            next_s.state = EMI_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         s                           <= '0;
         s.state                     <= EMI_IDLE;
         s.page_select_register      <= `EMI_PAGE_SEL_RESET;
         s.interface_config_register <= `EMI_CONFIG_RESET;
         s.rd_n                      <= 1'b1;
         s.wr_n                      <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register; no drive-mode outputs exist
   assign sfr_rdata_o   = s.sfr_rdata;
   assign xmove_rdata_o = s.rdata;
   assign xmove_done_o  = s.done;
   assign xmove_busy_o  = s.busy;
   assign ad_o          = s.ad_out;
   assign ad_oe_o       = s.ad_oe;
   assign addr_lo_o     = s.addr[7:0];
   assign addr_lo_oe_o  = s.alo_oe;
   assign addr_hi_o     = s.addr[15:8];
   assign addr_hi_oe_o  = s.ahi_oe;
   assign ale_o         = s.ale;
   assign ale_oe_o      = s.ale_oe;
   assign rd_n_o        = s.rd_n;
   assign wr_n_o        = s.wr_n;
   assign strobe_oe_o   = s.strobe_oe;
endmodule

// ### core/emi_phase_timer.sv
// Purpose: down counter that times each phase of an off-chip access
// Assumes: load value is the phase length minus one
// Notes:   expired is high in the last cycle of a phase
`timescale 1ns/10ps

module emi_phase_timer #(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         mclk_i,
   input  wire logic         reset_i,
   // control
   input  wire logic         load_i,
   input  wire logic [W-1:0] load_val_i,
   // status
   output logic              expired_o
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   always_comb begin
      next_cnt = cnt;
      if (load_i) begin
         next_cnt = load_val_i;
      end else if (cnt != '0) begin
         next_cnt = cnt - 1'b1;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign expired_o = (cnt == '0);
endmodule

// ### core/emi_ram.sv
// Purpose: on-chip data memory of the external data space
// Assumes: one clock, synchronous write, registered read
// Notes:   contents are not reset
`timescale 1ns/10ps

module emi_ram #(
   parameter int AW = 10,
   parameter int DW = 8
) (
   // clock
   input  wire logic mclk_i,
   // access port
   emi_ram_if.mem    bus
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] rdata;

   always_ff @(posedge mclk_i) begin
      if (bus.en) begin
         if (bus.we) begin
            mem[bus.addr] <= bus.wdata;
         end
         rdata <= mem[bus.addr];
      end
   end

   assign bus.rdata = rdata;
endmodule

// ### pkg/emi_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the
//          external data memory interface
// Assumes: included by bare name
// Notes:   definitions only
`ifndef EMI_MAP_SVH
`define EMI_MAP_SVH

// register addresses on the special function register port
`define EMI_PAGE_SEL_ADDR   8'haa
`define EMI_CONFIG_ADDR     8'hc7

// reset values
`define EMI_PAGE_SEL_RESET  8'h00
`define EMI_CONFIG_RESET    5'h03

// configuration fields
`define EMI_CFG_WIDTH       5
`define EMI_CFG_WMASK       5'h1f
`define EMI_CFG_MUX_BIT     4
`define EMI_CFG_MODE_HI     3
`define EMI_CFG_MODE_LO     2
`define EMI_CFG_ALE_HI      1
`define EMI_CFG_ALE_LO      0

// memory map modes
`define EMI_MODE_ONCHIP     2'h0
`define EMI_MODE_SPLIT      2'h1
`define EMI_MODE_BANK       2'h2
`define EMI_MODE_OFFCHIP    2'h3

// on-chip memory
`define EMI_ONCHIP_AW       10
`define EMI_ONCHIP_LIMIT    16'h0400

// timing defaults in system clock cycles
`define EMI_SETUP_CYC       4'h0
`define EMI_STROBE_CYC      4'h1
`define EMI_HOLD_CYC        4'h0
`define EMI_TIMER_W         4

`endif

// ### pkg/emi_pkg.sv
// Purpose: types of the external data memory interface
// Assumes: emi_map.svh on the include path
// Notes:   whole controller state is one packed struct
`include "emi_map.svh"

package emi_pkg;

   typedef enum logic [2:0] {
      EMI_IDLE,
      EMI_ON_WAIT,
      EMI_ALE_HIGH,
      EMI_ALE_LOW,
      EMI_ADDR,
      EMI_STROBE,
      EMI_HOLD
   } emi_state_t;

   typedef struct packed {
      emi_state_t                 state;
      logic [7:0]                 page_select_register;
      logic [`EMI_CFG_WIDTH-1:0]  interface_config_register;
      logic                       acc_wr;
      logic [15:0]                addr;
      logic [7:0]                 wdata;
      logic [7:0]                 rdata;
      logic [7:0]                 sfr_rdata;
      logic                       done;
      logic                       busy;
      logic [7:0]                 ad_out;
      logic                       ad_oe;
      logic                       alo_oe;
      logic                       ahi_oe;
      logic                       ale;
      logic                       ale_oe;
      logic                       rd_n;
      logic                       wr_n;
      logic                       strobe_oe;
   } emi_regs_t;

endpackage

// ### pkg/emi_ram_if.sv
// Purpose: carrier between the controller and the on-chip data memory
// Assumes: single clock, read data registered in the memory
// Notes:   ctrl side issues, mem side answers
`timescale 1ns/10ps

interface emi_ram_if #(
   parameter int AW = 10,
   parameter int DW = 8
);
   logic          en;
   logic          we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;

   modport ctrl (output en, output we, output addr, output wdata, input rdata);
   modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface

// ### testbench/emi_ctrl_properties.sv
// Purpose: bus and register properties of the external data memory interface
// Assumes: sees only the ports of emi_ctrl, default timing parameters
// Notes:   register shadows follow writes on the register port
`timescale 1ns/10ps

module emi_ctrl_properties (
   // clock and reset
   input wire logic        mclk_i,
   input wire logic        reset_i,
   // register port
   input wire logic [7:0]  sfr_addr_i,
   input wire logic        sfr_wr_i,
   input wire logic        sfr_rd_i,
   input wire logic [7:0]  sfr_wdata_i,
   input wire logic [7:0]  sfr_rdata_o,
   // request
   input wire logic        xmove_req_i,
   input wire logic        xmove_ptr8_i,
   input wire logic [15:0] data_pointer_16_i,
   input wire logic [7:0]  indirect_pointer_i,
   input wire logic        xmove_done_o,
   input wire logic        xmove_busy_o,
   // pins
   input wire logic        ad_oe_o,
   input wire logic [7:0]  addr_lo_o,
   input wire logic        addr_lo_oe_o,
   input wire logic [7:0]  addr_hi_o,
   input wire logic        addr_hi_oe_o,
   input wire logic        ale_o,
   input wire logic        ale_oe_o,
   input wire logic        rd_n_o,
   input wire logic        wr_n_o,
   input wire logic        strobe_oe_o
);
   logic [7:0]  pg;
   logic [4:0]  cf;
   logic [15:0] aa;
   logic [4:0]  cnt;
   logic [4:0]  len;
   logic        off;
   logic        p8;
   wire         take = xmove_req_i && !xmove_busy_o;
   wire  [15:0] ea   = xmove_ptr8_i ? {pg, indirect_pointer_i} : data_pointer_16_i;
   wire         goff = cf[3:2] == 2'h3 || (cf[3:2] != 2'h0 && ea >= 16'h0400);
   wire         pins = ad_oe_o || addr_lo_oe_o || addr_hi_oe_o || ale_oe_o || strobe_oe_o;
   wire         strb = !rd_n_o || !wr_n_o;

   // shadows and access length counter
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         pg  <= 8'h00;
         cf  <= 5'h03;
         aa  <= 16'h0000;
         cnt <= 5'h00;
         len <= 5'h00;
         off <= 1'b0;
         p8  <= 1'b0;
      end else begin
         if (sfr_wr_i && sfr_addr_i == 8'haa)
            pg <= sfr_wdata_i;
         if (sfr_wr_i && sfr_addr_i == 8'hc7)
            cf <= sfr_wdata_i[4:0];
         if (take) begin
            aa  <= ea;
            off <= goff;
            p8  <= xmove_ptr8_i;
            cnt <= 5'h01;
            len <= !goff ? 5'h02 : cf[4] ? 5'h04 : 5'h06 + {2'h0, cf[1:0], 1'b0};
         end else if (xmove_done_o)
            cnt <= 5'h00;
         else if (cnt != 5'h00)
            cnt <= cnt + 5'h01;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   property p_excl; !(!rd_n_o && !wr_n_o); endproperty
   a_excl: assert property (p_excl) else $error("both strobes low");
   property p_idle; !(xmove_busy_o && off) |-> !pins && rd_n_o && wr_n_o; endproperty
   a_idle: assert property (p_idle) else $error("pin claimed outside access");
   property p_claim; xmove_busy_o && off |-> strobe_oe_o; endproperty
   a_claim: assert property (p_claim) else $error("strobe pins not claimed");
   property p_rdin; !rd_n_o |-> !ad_oe_o && strobe_oe_o; endproperty
   a_rdin: assert property (p_rdin) else $error("data driven during read");
   property p_len; xmove_done_o |-> cnt == len; endproperty
   a_len: assert property (p_len) else $error("access length wrong");
   property p_busy; xmove_busy_o |-> cnt != 5'h00 && cnt < len; endproperty
   a_busy: assert property (p_busy) else $error("access overruns");
   property p_sep; strb |-> addr_lo_oe_o == cf[4] && ale_oe_o == !cf[4]; endproperty
   a_sep: assert property (p_sep) else $error("pin set wrong for mux mode");
   property p_ale; xmove_busy_o && off && !cf[4] |-> ale_o == (cnt <= cf[1:0] + 5'h01);
   endproperty
   a_ale: assert property (p_ale) else $error("latch strobe width wrong");
   property p_hi; strb |-> addr_hi_oe_o == (!p8 || cf[3:2] == 2'h2); endproperty
   a_hi: assert property (p_hi) else $error("upper address drive wrong");
   property p_addr; strb |-> (!addr_hi_oe_o || addr_hi_o == aa[15:8])
      && (!addr_lo_oe_o || addr_lo_o == aa[7:0]); endproperty
   a_addr: assert property (p_addr) else $error("address pins wrong");
   property p_cfgrd; sfr_rd_i && sfr_addr_i == 8'hc7 |=> sfr_rdata_o == {3'h0, $past(cf)};
   endproperty
   a_cfgrd: assert property (p_cfgrd) else $error("config read wrong");
endmodule

bind emi_ctrl emi_ctrl_properties chk_u (.*);

// ### testbench/emi_sram_model.sv
// Purpose: off-chip byte memory with address latch on the controller pins
// Assumes: latch follows shared lines while the latch strobe is high
// Notes:   undriven upper address lines rest at parked latch levels, the low byte at the address latch
`timescale 1ns/10ps

module emi_sram_model (
   // clock
   input wire logic       mclk_i,
   // controller pins
   input wire logic [7:0] ad_o,
   input wire logic [7:0] addr_lo_o,
   input wire logic       addr_lo_oe_o,
   input wire logic [7:0] addr_hi_o,
   input wire logic       addr_hi_oe_o,
   input wire logic       ale_o,
   input wire logic       ale_oe_o,
   input wire logic       rd_n_o,
   input wire logic       wr_n_o,
   input wire logic       strobe_oe_o,
   // parked upper address port latches
   input wire logic [7:0] park_hi_i,
   // data back to the controller
   output logic     [7:0] ad_i
);
   logic [7:0]  mem [0:65535];
   logic [7:0]  lat;
   wire  [15:0] a = {addr_hi_oe_o ? addr_hi_o : park_hi_i, addr_lo_oe_o ? addr_lo_o : lat};

   always @(posedge mclk_i) begin
      if (ale_oe_o && ale_o)
         lat <= ad_o;
      if (strobe_oe_o && !wr_n_o)
         mem[a] <= ad_o;
   end
   assign ad_i = (strobe_oe_o && !rd_n_o) ? mem[a] : 8'hff;
endmodule

// ### testbench/tb_top.sv
// Purpose: self-checking bench of the external data memory interface
// Assumes: default timing parameters of emi_ctrl
// Notes:   off-chip memory is the emi_sram_model partner
`timescale 1ns/10ps

module tb_top;
   logic mclk_i, reset_i, sfr_wr_i, sfr_rd_i, xmove_req_i, xmove_wr_i, xmove_ptr8_i;
   logic xmove_done_o, xmove_busy_o, ad_oe_o, addr_lo_oe_o, addr_hi_oe_o;
   logic ale_o, ale_oe_o, rd_n_o, wr_n_o, strobe_oe_o;
   logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, indirect_pointer_i, xmove_wdata_i;
   logic [7:0] xmove_rdata_o, ad_i, ad_o, addr_lo_o, addr_hi_o, park_hi_i, rd;
   logic [15:0] data_pointer_16_i, len;
   int bad_count = 0;
   int samples_checked = 0;
   int cycles = 0;

   emi_ctrl dut_u (.*);
   emi_sram_model sram_u (.*);

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      @(negedge mclk_i);
      sfr_wr_i = 1'b0;
   endtask

   task automatic sfr_rd(input logic [7:0] a);
      @(negedge mclk_i);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      @(negedge mclk_i);
      sfr_rd_i = 1'b0;
      @(negedge mclk_i);
      rd = sfr_rdata_o;
   endtask

   task automatic xmove(input logic w, input logic p8, input logic [15:0] adr,
                        input logic [7:0] wd);
      @(negedge mclk_i);
      xmove_req_i = 1'b1;
      xmove_wr_i = w;
      xmove_ptr8_i = p8;
      data_pointer_16_i = adr;
      indirect_pointer_i = adr[7:0];
      xmove_wdata_i = wd;
      @(negedge mclk_i);
      xmove_req_i = 1'b0;
      len = 16'h1;
      while (xmove_done_o !== 1'b1 && len < 16'd40) begin
         @(negedge mclk_i);
         len++;
      end
      if (xmove_done_o !== 1'b1) begin
         bad_count++;
         $display("mismatch xmove done expected 1 seen %b", xmove_done_o);
      end
      rd = xmove_rdata_o;
   endtask

   task automatic t_regs;
      sfr_rd(8'haa);
      check("page reset", 16'h00, rd);
      sfr_rd(8'hc7);
      check("config reset", 16'h03, rd);
      sfr_wr(8'hc7, 8'hff);
      sfr_rd(8'hc7);
      check("config upper bits", 16'h1f, rd);
      sfr_wr(8'haa, 8'h5a);
      sfr_rd(8'haa);
      check("page value", 16'h5a, rd);
      sfr_wr(8'h55, 8'h77);
      sfr_rd(8'h55);
      check("unmapped", 16'h00, rd);
      sfr_wr(8'hc7, 8'h03);
      $display("test regs done");
   endtask

   task automatic t_onchip;
      xmove(1'b1, 1'b0, 16'h03ff, 8'ha5);
      check("onchip cycles", 16'h2, len);
      xmove(1'b0, 1'b0, 16'hfbff, 8'h00);
      check("alias read", 16'ha5, rd);
      sfr_wr(8'haa, 8'h13);
      xmove(1'b0, 1'b1, 16'h00ff, 8'h00);
      check("page read", 16'ha5, rd);
      $display("test onchip done");
   endtask

   task automatic t_split;
      sfr_wr(8'hc7, 8'h14);
      xmove(1'b1, 1'b0, 16'h0400, 8'h3c);
      check("split cycles", 16'h4, len);
      check("split write", 16'h3c, sram_u.mem[16'h0400]);
      sfr_wr(8'haa, 8'h08);
      park_hi_i = 8'h77;
      xmove(1'b1, 1'b1, 16'h0021, 8'h99);
      check("latch page write", 16'h99, sram_u.mem[16'h7721]);
      xmove(1'b0, 1'b1, 16'h0021, 8'h00);
      check("latch page read", 16'h99, rd);
      xmove(1'b0, 1'b0, 16'h03ff, 8'h00);
      check("onchip kept", 16'ha5, rd);
      $display("test split done");
   endtask

   task automatic t_bank;
      sfr_wr(8'hc7, 8'h18);
      sfr_wr(8'haa, 8'h12);
      xmove(1'b1, 1'b1, 16'h0034, 8'h5e);
      check("bank write", 16'h5e, sram_u.mem[16'h1234]);
      sfr_wr(8'haa, 8'h02);
      xmove(1'b1, 1'b1, 16'h0000, 8'h11);
      check("bank low page", 16'h00, sram_u.mem[16'h0200]);
      xmove(1'b0, 1'b0, 16'h0200, 8'h00);
      check("bank onchip read", 16'h11, rd);
      $display("test bank done");
   endtask

   task automatic t_ext;
      sfr_wr(8'hc7, 8'h1c);
      xmove(1'b1, 1'b0, 16'h03ff, 8'h6b);
      check("ext write", 16'h6b, sram_u.mem[16'h03ff]);
      xmove(1'b0, 1'b0, 16'h03ff, 8'h00);
      check("ext read", 16'h6b, rd);
      xmove(1'b1, 1'b1, 16'h0044, 8'hc3);
      check("ext short write", 16'hc3, sram_u.mem[16'h7744]);
      sfr_wr(8'hc7, 8'h00);
      xmove(1'b0, 1'b0, 16'h03ff, 8'h00);
      check("onchip intact", 16'ha5, rd);
      $display("test ext done");
   endtask

   task automatic t_mux;
      for (int w = 0; w < 4; w++) begin
         sfr_wr(8'hc7, 8'h0c + 8'(w));
         xmove(1'b1, 1'b0, 16'h8000 + 16'(w), 8'h40 + 8'(w));
         check("mux cycles", 16'h6 + 16'(2 * w), len);
         xmove(1'b0, 1'b0, 16'h8000 + 16'(w), 8'h00);
         check("mux read", 16'h40 + 16'(w), rd);
      end
      $display("test mux done");
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         $display("mismatch timeout expected finish seen cycle %0d", cycles);
         final_report;
      end
   end

   initial begin
      reset_i = 1'b1;
      {sfr_wr_i, sfr_rd_i, xmove_req_i, xmove_wr_i, xmove_ptr8_i} = 5'h00;
      {sfr_addr_i, sfr_wdata_i, indirect_pointer_i, xmove_wdata_i} = 32'h0;
      data_pointer_16_i = 16'h0000;
      park_hi_i = 8'hff;
      sram_u.mem[16'h0200] = 8'h00;
      repeat (16) @(negedge mclk_i);
      reset_i = 1'b0;
      t_regs;
      t_onchip;
      t_split;
      t_bank;
      t_ext;
      t_mux;
      final_report;
   end
endmodule
